// [common/fcmc_pkg.sv]
package fcmc_pkg;
	localparam int CLK_MHZ = 200;
	localparam int T_SETUP_NS = 10;
	localparam int T_WP_NS = 35;
	localparam int T_HOLD_NS = 20;
	localparam int T_ACC_NS = 90;
	localparam int T_RP_NS = 500;
	localparam int T_RH_NS = 50;
	localparam logic [7:0] SETUP_CNT = 8'((T_SETUP_NS * CLK_MHZ + 999) / 1000);
	localparam logic [7:0] WP_CNT = 8'((T_WP_NS * CLK_MHZ + 999) / 1000);
	localparam logic [7:0] HOLD_CNT = 8'((T_HOLD_NS * CLK_MHZ + 999) / 1000);
	localparam logic [7:0] ACC_CNT = 8'((T_ACC_NS * CLK_MHZ + 999) / 1000);
	localparam logic [7:0] RP_CNT = 8'((T_RP_NS * CLK_MHZ + 999) / 1000);
	localparam logic [7:0] RH_CNT = 8'((T_RH_NS * CLK_MHZ + 999) / 1000);
	localparam logic [7:0] SYNC_CNT = 8'h02;
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_ADDR = 8'h04;
	localparam logic [7:0] REG_WDATA = 8'h08;
	localparam logic [7:0] REG_CMD = 8'h0C;
	localparam logic [7:0] REG_RDATA = 8'h10;
	localparam logic [7:0] REG_STATUS = 8'h14;
	localparam logic [2:0] CTRL_RST = 3'h0;
	localparam int CTRL_BYTE = 0;
	localparam int ST_REFUSED = 1;
	localparam logic [7:0] ID_MFR_OFS = 8'h00;
	localparam logic [7:0] ID_DEV_WORD = 8'h01;
	localparam logic [7:0] ID_DEV_BYTE = 8'h02;
	localparam logic [7:0] ID_PROT_WORD = 8'h02;
	localparam logic [7:0] ID_PROT_BYTE = 8'h04;
	typedef enum logic [3:0] {
		OP_WRITE, OP_READ, OP_RESET, OP_AUTOSEL, OP_SEC_ENTER,
		OP_SEC_EXIT, OP_QUERY, OP_ID_READ, OP_QRY_READ, OP_HW_RESET
	} fcmc_op_t;
endpackage

// [src/fcmc_cycle.sv]
`timescale 1ns/1ps
`default_nettype none
module fcmc_cycle (
	input wire logic clk_sys,
	input wire logic resetn,
	input wire logic start,
	input wire logic rd,
	input wire logic [20:0] addr,
	input wire logic [15:0] wdata,
	input wire logic byte_mode,
	input wire logic [15:0] dq_i,
	output logic [19:0] a_q,
	output logic alsb_q,
	output logic [15:0] dq_o_q,
	output logic dq_oe_q,
	output logic ce_n_q,
	output logic we_n_q,
	output logic oe_n_q,
	output logic done_q,
	output logic [15:0] rdata_q
);
	typedef enum {C_IDLE, C_SETUP, C_STROBE, C_SAMPLE, C_HOLD} fcmc_cyc_t;
	fcmc_cyc_t state_q;
	logic rd_q;
	logic [7:0] cnt_q;
	logic [15:0] dq_s1_q;
	logic [15:0] dq_s2_q;
	wire cnt_end = (cnt_q == 8'h01);
	wire [7:0] cnt_dec = cnt_q - 8'h01;

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			dq_s1_q <= 16'h0000;
			dq_s2_q <= 16'h0000;
		end else begin
			dq_s1_q <= dq_i;
			dq_s2_q <= dq_s1_q;
		end
	end

	// chip select falls first and rises last, so the write strobe edges decide
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			state_q <= C_IDLE;
			rd_q <= 1'b0;
			cnt_q <= 8'h00;
			a_q <= 20'h00000;
			alsb_q <= 1'b0;
			dq_o_q <= 16'h0000;
			dq_oe_q <= 1'b0;
			ce_n_q <= 1'b1;
			we_n_q <= 1'b1;
			oe_n_q <= 1'b1;
			done_q <= 1'b0;
			rdata_q <= 16'h0000;
		end else begin
			done_q <= 1'b0;
			cnt_q <= cnt_dec;
			case (state_q)
				C_IDLE: begin
					cnt_q <= fcmc_pkg::SETUP_CNT;
					if (start) begin
						rd_q <= rd;
						a_q <= byte_mode ? addr[20:1] : addr[19:0];
						alsb_q <= byte_mode & addr[0];
						dq_o_q <= wdata;
						dq_oe_q <= ~rd;
						ce_n_q <= 1'b0;
						state_q <= C_SETUP;
					end
				end
				C_SETUP: if (cnt_end) begin
					we_n_q <= rd_q;
					oe_n_q <= ~rd_q;
					cnt_q <= rd_q ? fcmc_pkg::ACC_CNT : fcmc_pkg::WP_CNT;
					state_q <= C_STROBE;
				end
				C_STROBE: if (cnt_end) begin
					we_n_q <= 1'b1;
					cnt_q <= rd_q ? fcmc_pkg::SYNC_CNT : fcmc_pkg::HOLD_CNT;
					state_q <= rd_q ? C_SAMPLE : C_HOLD;
				end
				C_SAMPLE: if (cnt_end) begin
					rdata_q <= dq_s2_q;
					oe_n_q <= 1'b1;
					cnt_q <= fcmc_pkg::HOLD_CNT;
					state_q <= C_HOLD;
				end
				C_HOLD: if (cnt_end) begin
					ce_n_q <= 1'b1;
					dq_oe_q <= 1'b0;
					done_q <= 1'b1;
					state_q <= C_IDLE;
				end
				default: state_q <= C_IDLE;
			endcase
		end
	end
endmodule
`default_nettype wire

// [src/fcmc_top.sv]
`timescale 1ns/1ps
`default_nettype none
module fcmc_top #(
	parameter int BANK_BIT = 19,
	parameter logic [20:0] UL1_ADDR = 21'h000001,
	parameter logic [15:0] UL1_DATA = 16'h0001,
	parameter logic [20:0] UL2_ADDR = 21'h000002,
	parameter logic [15:0] UL2_DATA = 16'h0002,
	parameter logic [15:0] RESET_DATA = 16'h0003,
	parameter logic [15:0] AUTOSEL_DATA = 16'h0004,
	parameter logic [15:0] SEC_ENTER_DATA = 16'h0005,
	parameter logic [15:0] SEC_EXIT_DATA = 16'h0006,
	parameter logic [20:0] SEC_EXIT2_ADDR = 21'h000000,
	parameter logic [15:0] SEC_EXIT2_DATA = 16'h0000,
	parameter logic [20:0] QUERY_ADDR = 21'h000003,
	parameter logic [15:0] QUERY_DATA = 16'h0007
) (
	input wire logic clk_sys,
	input wire logic resetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic [31:0] hrdata,
	output logic hresp,
	output logic [19:0] flash_addr,
	output logic flash_alsb,
	input wire logic [15:0] flash_dq_i,
	output logic [15:0] flash_dq_o,
	output logic flash_dq_oe,
	output logic flash_ce_n,
	output logic flash_we_n,
	output logic flash_oe_n,
	output logic flash_reset_n,
	output logic flash_byte_n
);
	typedef enum {S_IDLE, S_ISSUE, S_WAIT, S_RST_LOW, S_RST_REC} fcmc_seq_t;
	fcmc_seq_t state_q;
	fcmc_pkg::fcmc_op_t op_q;
	logic [2:0] ctrl_q;
	logic [20:0] addr_q;
	logic [15:0] wdata_q;
	logic [15:0] rdata_q;
	logic [1:0] step_q;
	logic [7:0] cnt_q;
	logic bank_q;
	logic start_q;
	logic refused_q;
	logic secure_q;
	logic query_q;
	logic [1:0] autosel_q;
	logic dp_wr_q;
	logic [7:0] dp_addr_q;
	logic hreadyout_q;
	logic [31:0] hrdata_q;
	logic flash_reset_n_q;
	logic flash_byte_n_q;
	logic [20:0] st_addr;
	logic [15:0] st_data;
	logic st_rd;
	logic st_last;
	logic cyc_done;
	logic [15:0] cyc_rdata;

	assign hreadyout = hreadyout_q;
	assign hrdata = hrdata_q;
	assign hresp = 1'b0;
	assign flash_reset_n = flash_reset_n_q;
	assign flash_byte_n = flash_byte_n_q;

	wire byte_mode = ctrl_q[fcmc_pkg::CTRL_BYTE];
	wire busy = (state_q != S_IDLE);
	wire ap_take = hsel & htrans[1] & hready;
	wire wr_ctrl = dp_wr_q & (dp_addr_q == fcmc_pkg::REG_CTRL);
	wire wr_addr = dp_wr_q & (dp_addr_q == fcmc_pkg::REG_ADDR);
	wire wr_wdata = dp_wr_q & (dp_addr_q == fcmc_pkg::REG_WDATA);
	wire cmd_wr = dp_wr_q & (dp_addr_q == fcmc_pkg::REG_CMD);
	wire wr_status = dp_wr_q & (dp_addr_q == fcmc_pkg::REG_STATUS);
	wire [3:0] op_code = hwdata[3:0];
	wire fcmc_pkg::fcmc_op_t op_in = fcmc_pkg::fcmc_op_t'(op_code);
	wire bank_sel = byte_mode ? addr_q[BANK_BIT + 1] : addr_q[BANK_BIT];
	wire other_active = ctrl_q[2 - {1'b0, bank_sel}];
	// unknown opcodes, autoselect with the other bank active, and ID reads or secure exits out of mode are refused so the device never sees them
	wire op_ok = (op_code <= 4'(fcmc_pkg::OP_HW_RESET))
		& ~((op_in == fcmc_pkg::OP_AUTOSEL) & other_active)
		& ~((op_in == fcmc_pkg::OP_ID_READ) & ~autosel_q[bank_sel])
		& ~((op_in == fcmc_pkg::OP_SEC_EXIT) & ~secure_q);
	wire go = cmd_wr & ~busy & op_ok;
	wire refuse = cmd_wr & ~go;
	wire apply = (state_q == S_WAIT) & cyc_done & st_last;
	wire [7:0] id_dev = byte_mode ? fcmc_pkg::ID_DEV_BYTE : fcmc_pkg::ID_DEV_WORD;
	wire [7:0] id_prot = byte_mode ? fcmc_pkg::ID_PROT_BYTE : fcmc_pkg::ID_PROT_WORD;
	wire [7:0] id_ofs = (wdata_q[1:0] == 2'h0) ? fcmc_pkg::ID_MFR_OFS :
		(wdata_q[1:0] == 2'h1) ? id_dev : id_prot;
	// query word addresses double in byte mode
	wire [20:0] qry_addr = byte_mode ? {12'h000, wdata_q[7:0], 1'b0} :
		{13'h0000, wdata_q[7:0]};
	wire [31:0] status_w = {26'h0000000, query_q, secure_q, autosel_q, refused_q, busy};
	wire [31:0] rd_mux = (haddr[7:0] == fcmc_pkg::REG_CTRL) ? {29'h00000000, ctrl_q} :
		(haddr[7:0] == fcmc_pkg::REG_ADDR) ? {11'h000, addr_q} :
		(haddr[7:0] == fcmc_pkg::REG_WDATA) ? {16'h0000, wdata_q} :
		(haddr[7:0] == fcmc_pkg::REG_RDATA) ? {16'h0000, rdata_q} :
		(haddr[7:0] == fcmc_pkg::REG_STATUS) ? status_w : 32'h00000000;

	always_comb begin
		st_addr = addr_q;
		st_data = wdata_q;
		st_rd = 1'b0;
		st_last = 1'b1;
		case (op_q)
			fcmc_pkg::OP_READ: st_rd = 1'b1;
			fcmc_pkg::OP_RESET: st_data = RESET_DATA;
			fcmc_pkg::OP_AUTOSEL, fcmc_pkg::OP_SEC_ENTER, fcmc_pkg::OP_SEC_EXIT: begin
				st_last = 1'b0;
				case (step_q)
					2'h0: begin
						st_addr = UL1_ADDR;
						st_data = UL1_DATA;
					end
					2'h1: begin
						st_addr = UL2_ADDR;
						st_data = UL2_DATA;
					end
					2'h2: begin
						st_last = (op_q != fcmc_pkg::OP_SEC_EXIT);
						st_addr = (op_q == fcmc_pkg::OP_AUTOSEL) ? addr_q : UL1_ADDR;
						st_data = (op_q == fcmc_pkg::OP_AUTOSEL) ? AUTOSEL_DATA :
							(op_q == fcmc_pkg::OP_SEC_ENTER) ? SEC_ENTER_DATA : SEC_EXIT_DATA;
					end
					default: begin
						st_addr = SEC_EXIT2_ADDR;
						st_data = SEC_EXIT2_DATA;
						st_last = 1'b1;
					end
				endcase
			end
			fcmc_pkg::OP_QUERY: begin
				st_addr = QUERY_ADDR;
				st_data = QUERY_DATA;
			end
			fcmc_pkg::OP_ID_READ: begin
				st_rd = 1'b1;
				st_addr = {addr_q[20:8], id_ofs};
			end
			fcmc_pkg::OP_QRY_READ: begin
				st_rd = 1'b1;
				st_addr = qry_addr;
			end
			default: st_last = 1'b1;
		endcase
	end

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			dp_wr_q <= 1'b0;
			dp_addr_q <= 8'h00;
			hreadyout_q <= 1'b1;
			hrdata_q <= 32'h00000000;
		end else begin
			dp_wr_q <= ap_take & hwrite;
			dp_addr_q <= haddr[7:0];
			if (ap_take & ~hwrite) begin
				hrdata_q <= rd_mux;
			end
		end
	end

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			ctrl_q <= fcmc_pkg::CTRL_RST;
			addr_q <= 21'h000000;
			wdata_q <= 16'h0000;
			flash_byte_n_q <= 1'b1;
		end else begin
			if (wr_ctrl) ctrl_q <= hwdata[2:0];
			if (wr_addr) addr_q <= hwdata[20:0];
			if (wr_wdata) wdata_q <= hwdata[15:0];
			flash_byte_n_q <= ~byte_mode;
		end
	end

	// a refusal in the same cycle as its clear stays set
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			refused_q <= 1'b0;
		end else begin
			refused_q <= refuse | (refused_q & ~(wr_status & hwdata[fcmc_pkg::ST_REFUSED]));
		end
	end

	// mode tracking starts in read-array; autoselect entry follows each bank apart, while a reset command clears both banks
	generate
		for (genvar b = 0; b < 2; b++) begin : g_bank
			always_ff @(posedge clk_sys or negedge resetn) begin
				if (!resetn) begin
					autosel_q[b] <= 1'b0;
				end else if (state_q == S_RST_REC) begin
					autosel_q[b] <= 1'b0;
				end else if (apply & (op_q == fcmc_pkg::OP_RESET)) begin
					autosel_q[b] <= 1'b0;
				end else if (apply & (op_q == fcmc_pkg::OP_AUTOSEL) & (bank_q == b)) begin
					autosel_q[b] <= 1'b1;
				end
			end
		end
	endgenerate

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			secure_q <= 1'b0;
			query_q <= 1'b0;
		end else if (state_q == S_RST_REC) begin
			secure_q <= 1'b0;
			query_q <= 1'b0;
		end else if (apply) begin
			if (op_q == fcmc_pkg::OP_SEC_ENTER) secure_q <= 1'b1;
			if (op_q == fcmc_pkg::OP_SEC_EXIT) secure_q <= 1'b0;
			if (op_q == fcmc_pkg::OP_QUERY) query_q <= 1'b1;
			if (op_q == fcmc_pkg::OP_RESET) query_q <= 1'b0;
		end
	end

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			state_q <= S_IDLE;
			op_q <= fcmc_pkg::OP_WRITE;
			bank_q <= 1'b0;
			step_q <= 2'h0;
			cnt_q <= 8'h00;
			start_q <= 1'b0;
			rdata_q <= 16'h0000;
			flash_reset_n_q <= 1'b1;
		end else begin
			start_q <= 1'b0;
			cnt_q <= cnt_q - 8'h01;
			case (state_q)
				S_IDLE: if (go) begin
					op_q <= op_in;
					bank_q <= bank_sel;
					step_q <= 2'h0;
					cnt_q <= fcmc_pkg::RP_CNT;
					flash_reset_n_q <= (op_in != fcmc_pkg::OP_HW_RESET);
					state_q <= (op_in == fcmc_pkg::OP_HW_RESET) ? S_RST_LOW : S_ISSUE;
				end
				S_ISSUE: begin
					start_q <= 1'b1;
					state_q <= S_WAIT;
				end
				S_WAIT: if (cyc_done) begin
					if (st_rd) rdata_q <= cyc_rdata;
					step_q <= step_q + 2'h1;
					state_q <= st_last ? S_IDLE : S_ISSUE;
				end
				S_RST_LOW: if (cnt_q == 8'h01) begin
					flash_reset_n_q <= 1'b1;
					cnt_q <= fcmc_pkg::RH_CNT;
					state_q <= S_RST_REC;
				end
				S_RST_REC: if (cnt_q == 8'h01) state_q <= S_IDLE;
				default: state_q <= S_IDLE;
			endcase
		end
	end

	fcmc_cycle u_cycle (
		.clk_sys(clk_sys),
		.resetn(resetn),
		.start(start_q),
		.rd(st_rd),
		.addr(st_addr),
		.wdata(st_data),
		.byte_mode(byte_mode),
		.dq_i(flash_dq_i),
		.a_q(flash_addr),
		.alsb_q(flash_alsb),
		.dq_o_q(flash_dq_o),
		.dq_oe_q(flash_dq_oe),
		.ce_n_q(flash_ce_n),
		.we_n_q(flash_we_n),
		.oe_n_q(flash_oe_n),
		.done_q(cyc_done),
		.rdata_q(cyc_rdata)
	);

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!resetn);

	addr_before_we_a: assert property ($fell(flash_we_n) |-> !flash_ce_n && $stable(flash_addr))
		else $error("write strobe fell without chip select or with moving address");
	data_hold_a: assert property ($rose(flash_we_n) |-> flash_dq_oe && $stable(flash_dq_o))
		else $error("write data not held at write strobe rise");
	ce_covers_we_a: assert property ($rose(flash_ce_n) |-> flash_we_n && $past(flash_we_n))
		else $error("chip select rose while write strobe low");
	busy_refuse_a: assert property (cmd_wr && busy |=> refused_q && $stable(op_q))
		else $error("command taken while busy");
	other_bank_a: assert property (cmd_wr && !busy && op_in == fcmc_pkg::OP_AUTOSEL
		&& other_active |=> state_q == S_IDLE ##1 state_q == S_IDLE)
		else $error("autoselect issued while other bank active");
	autosel_len_a: assert property (apply && op_q == fcmc_pkg::OP_AUTOSEL |-> step_q == 2'h2
		##1 autosel_q[bank_q])
		else $error("autoselect entry not three cycles");
	sec_len_a: assert property (apply && (op_q == fcmc_pkg::OP_SEC_ENTER
		|| op_q == fcmc_pkg::OP_SEC_EXIT) |-> step_q == ((op_q == fcmc_pkg::OP_SEC_EXIT)
		? 2'h3 : 2'h2))
		else $error("secure sequence length wrong");
	reset_clears_a: assert property (apply && op_q == fcmc_pkg::OP_RESET
		|=> autosel_q == 2'h0 && !query_q)
		else $error("reset command did not clear autoselect");
	hw_reset_a: assert property ($rose(flash_reset_n) |-> $past(flash_reset_n, 8)
		== 1'b0 ##1 !secure_q && autosel_q == 2'h0)
		else $error("hardware reset pulse short or modes kept");
	qry_double_a: assert property (start_q && op_q == fcmc_pkg::OP_QRY_READ && byte_mode
		|-> st_addr[0] == 1'b0 && st_addr[8:1] == wdata_q[7:0])
		else $error("query byte address not doubled");
	strobe_excl_a: assert property (!(!flash_we_n && !flash_oe_n))
		else $error("write and output strobes low together");

	autosel_c: cover property (apply && op_q == fcmc_pkg::OP_AUTOSEL);
	sec_exit_c: cover property (apply && op_q == fcmc_pkg::OP_SEC_EXIT);
	hw_reset_c: cover property ($rose(flash_reset_n));
	refuse_c: cover property (refuse);
endmodule
`default_nettype wire

// [test/fcmc_flash_model.sv]
`timescale 1ns/1ps
`default_nettype none
module fcmc_flash_model #(
	parameter int RD_DLY = 0,
	parameter logic [15:0] MFR_CODE = 16'h00A5,
	parameter logic [15:0] DEV_CODE = 16'h225A,
	parameter logic [15:0] BANK2_SECT = 16'h0012,
	parameter logic [15:0] BOOT_FLAG = 16'h0002,
	parameter logic [5:0] SI_REV = 6'h01,
	parameter logic [20:0] UL1_ADDR = 21'h000001,
	parameter logic [15:0] UL1_DATA = 16'h0001,
	parameter logic [20:0] UL2_ADDR = 21'h000002,
	parameter logic [15:0] UL2_DATA = 16'h0002,
	parameter logic [15:0] RESET_DATA = 16'h0003,
	parameter logic [15:0] AUTOSEL_DATA = 16'h0004,
	parameter logic [15:0] SEC_ENTER_DATA = 16'h0005,
	parameter logic [15:0] SEC_EXIT_DATA = 16'h0006,
	parameter logic [20:0] SEC_EXIT2_ADDR = 21'h000000,
	parameter logic [15:0] SEC_EXIT2_DATA = 16'h0000,
	parameter logic [20:0] QUERY_ADDR = 21'h000003,
	parameter logic [15:0] QUERY_DATA = 16'h0007
) (
	input wire logic [19:0] addr,
	input wire logic alsb,
	input wire logic [15:0] dq_in,
	input wire logic ce_n,
	input wire logic we_n,
	input wire logic oe_n,
	input wire logic reset_n,
	input wire logic byte_n,
	output wire logic [15:0] dq
);
	logic [20:0] lat_a;
	logic wr_on = 1'b0;
	logic [1:0] seq = 2'd0;
	logic [1:0] auto_q = 2'b00;
	logic sec_q = 1'b0;
	logic qry_q = 1'b0;
	logic [15:0] hold_q = 16'hA5A5;
	logic [15:0] qv;
	logic [15:0] rv;
	logic [7:0] ofs;

	task automatic cmd(input logic [20:0] a, input logic [15:0] d);
		logic bk;
		bk = byte_n ? a[19] : a[20];
		if (d == RESET_DATA) begin
			auto_q = 2'b00;
			qry_q = 1'b0;
			seq = 2'd0;
		end else if (seq == 2'd0 && a == UL1_ADDR && d == UL1_DATA) begin
			seq = 2'd1;
		end else if (seq == 2'd0 && a == QUERY_ADDR && d == QUERY_DATA) begin
			qry_q = 1'b1;
		end else if (seq == 2'd1 && a == UL2_ADDR && d == UL2_DATA) begin
			seq = 2'd2;
		end else if (seq == 2'd2 && d == AUTOSEL_DATA) begin
			auto_q[bk] = 1'b1;
			seq = 2'd0;
		end else if (seq == 2'd2 && a == UL1_ADDR && d == SEC_ENTER_DATA) begin
			sec_q = 1'b1;
			seq = 2'd0;
		end else if (seq == 2'd2 && a == UL1_ADDR && d == SEC_EXIT_DATA) begin
			seq = 2'd3;
		end else begin
			if (seq == 2'd3 && a == SEC_EXIT2_ADDR && d == SEC_EXIT2_DATA)
				sec_q = 1'b0;
			seq = 2'd0;
		end
	endtask

	always @(negedge we_n or negedge ce_n) begin
		if (!we_n && !ce_n && reset_n) begin
			wr_on = 1'b1;
			lat_a = byte_n ? {1'b0, addr} : {addr, alsb};
		end
	end
	always @(posedge we_n or posedge ce_n) begin
		if (wr_on) begin
			wr_on = 1'b0;
			cmd(lat_a, dq_in);
		end
	end
	always @(negedge reset_n) begin
		auto_q = 2'b00;
		sec_q = 1'b0;
		qry_q = 1'b0;
		seq = 2'd0;
		wr_on = 1'b0;
	end

	always_comb begin
		ofs = byte_n ? addr[7:0] : {addr[6:0], alsb};
		case (addr[7:0])
			8'h40: qv = 16'h0050;
			8'h41: qv = 16'h0052;
			8'h42: qv = 16'h0049;
			8'h43, 8'h44: qv = 16'h0031;
			8'h45: qv = {8'h00, SI_REV, 2'b00};
			8'h46, 8'h4F: qv = (addr[0]) ? BOOT_FLAG : 16'h0002;
			8'h47, 8'h48: qv = 16'h0001;
			8'h49: qv = 16'h0004;
			8'h4A: qv = BANK2_SECT;
			8'h4D: qv = 16'h0085;
			8'h4E: qv = 16'h0095;
			default: qv = 16'h0000;
		endcase
		if (qry_q)
			rv = (byte_n || !alsb) ? qv : 16'h00FF;
		else if (auto_q[addr[19]] && ofs == 8'h00)
			rv = MFR_CODE;
		else if (auto_q[addr[19]] && ofs == (byte_n ? 8'h01 : 8'h02))
			rv = DEV_CODE;
		else if (auto_q[addr[19]] && ofs == (byte_n ? 8'h02 : 8'h04))
			rv = {15'h0000, addr[15]};
		else if (auto_q[addr[19]])
			rv = 16'h0000;
		else
			rv = addr[15:0] ^ (sec_q ? 16'hC3C3 : 16'h3C3C);
	end
	// released bus shows the inverse of the last word, never a stale copy
	always @(posedge oe_n) hold_q = ~rv;
	assign #(RD_DLY) dq = (!ce_n && !oe_n && reset_n) ? rv : hold_q;
endmodule
`default_nettype wire

// [test/fcmc_tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin n_fail++; $display("Error at %0t: got %h expected %h", $time, (g), (e)); end end
module fcmc_tb_top;
	localparam logic [15:0] MFR = 16'h00A5; // arbitrary value
	localparam logic [15:0] DEV = 16'h225A; // arbitrary value
	localparam logic [15:0] NSECT = 16'h0012;
	localparam logic [15:0] BOOT = 16'h0003;
	localparam logic [15:0] QTAB [16] = '{16'h0050, 16'h0052, 16'h0049, 16'h0031, 16'h0031,
		16'h0004, 16'h0002, 16'h0001, 16'h0001, 16'h0004, NSECT, 16'h0000, 16'h0000,
		16'h0085, 16'h0095, BOOT};
	logic clk_sys = 1'b0;
	logic resetn, hsel, hwrite;
	logic [31:0] haddr, hwdata;
	logic [1:0] htrans;
	logic [2:0] hsize;
	wire logic hreadyout, hresp, f_alsb, f_oe, f_ce_n, f_we_n, f_oe_n, f_rst_n, f_byte_n;
	wire logic [31:0] hrdata;
	wire logic [19:0] f_addr;
	wire logic [15:0] f_dq_o, m_dq, dq_wire;
	int n_fail = 0;
	int num_checks = 0;
	int cyc = 0;
	int i;

	assign dq_wire = f_oe ? f_dq_o : m_dq;
	always #2.5 clk_sys = ~clk_sys;

	fcmc_top fcmc_top_i (.clk_sys(clk_sys), .resetn(resetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
		.hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .flash_addr(f_addr),
		.flash_alsb(f_alsb), .flash_dq_i(dq_wire), .flash_dq_o(f_dq_o), .flash_dq_oe(f_oe),
		.flash_ce_n(f_ce_n), .flash_we_n(f_we_n), .flash_oe_n(f_oe_n),
		.flash_reset_n(f_rst_n), .flash_byte_n(f_byte_n));
	fcmc_flash_model #(.RD_DLY(60), .MFR_CODE(MFR), .DEV_CODE(DEV), .BANK2_SECT(NSECT),
		.BOOT_FLAG(BOOT), .SI_REV(6'h01)) fcmc_flash_model_i (.addr(f_addr), .alsb(f_alsb),
		.dq_in(dq_wire), .ce_n(f_ce_n), .we_n(f_we_n), .oe_n(f_oe_n), .reset_n(f_rst_n),
		.byte_n(f_byte_n), .dq(m_dq));

	task automatic end_sim;
		$display("checks %0d mismatches %0d", num_checks, n_fail);
		if (n_fail == 0 && num_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	always @(posedge clk_sys) begin
		cyc++;
		if (cyc == 40000) begin
			n_fail++;
			$display("Error at %0t: run did not finish", $time);
			end_sim();
		end
	end

	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] wd,
		output logic [31:0] rdat);
		@(posedge clk_sys);
		haddr <= {24'h000000, a};
		htrans <= 2'h2;
		hwrite <= w;
		do @(posedge clk_sys); while (hreadyout !== 1'b1);
		htrans <= 2'h0;
		hwdata <= wd;
		do @(posedge clk_sys); while (hreadyout !== 1'b1);
		rdat = hrdata;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] unused;
		xfer(1'b1, a, d, unused);
	endtask
	task automatic chk(input logic [7:0] a, input logic [31:0] e);
		logic [31:0] r;
		xfer(1'b0, a, 32'h00000000, r);
		`CHK(r, e)
	endtask
	// start an operation and poll busy; the walk puts busy up within four cycles
	task automatic run(input logic [3:0] op, input logic [20:0] a, input logic [15:0] d);
		logic [31:0] s;
		wr(fcmc_pkg::REG_ADDR, {11'h000, a});
		wr(fcmc_pkg::REG_WDATA, {16'h0000, d});
		wr(fcmc_pkg::REG_CMD, {28'h0000000, op});
		repeat (4) @(posedge clk_sys);
		s = 32'h00000001;
		while (s[0] === 1'b1)
			xfer(1'b0, fcmc_pkg::REG_STATUS, 32'h00000000, s);
	endtask
	task automatic rdv(input logic [3:0] op, input logic [20:0] a, input logic [15:0] d,
		input logic [15:0] e);
		run(op, a, d);
		chk(fcmc_pkg::REG_RDATA, {16'h0000, e});
	endtask

	initial begin
		resetn = 1'b0;
		hsel = 1'b1;
		haddr = 32'h00000000;
		htrans = 2'h0;
		hwrite = 1'b0;
		hsize = 3'h2;
		hwdata = 32'h00000000;
		repeat (20) @(posedge clk_sys);
		resetn <= 1'b1;
		chk(fcmc_pkg::REG_CTRL, 32'h00000000);
		chk(fcmc_pkg::REG_STATUS, 32'h00000000);
		chk(fcmc_pkg::REG_CMD, 32'h00000000);
		chk(8'h20, 32'h00000000);
		`CHK(hresp, 1'b0)
		rdv(fcmc_pkg::OP_READ, 21'h000123, 16'h0000, 16'h3D1F);
		rdv(fcmc_pkg::OP_READ, 21'h080456, 16'h0000, 16'h386A);
		$display("test power_up done");
		run(fcmc_pkg::OP_AUTOSEL, 21'h080000, 16'h0000);
		chk(fcmc_pkg::REG_STATUS, 32'h00000008);
		rdv(fcmc_pkg::OP_ID_READ, 21'h080000, 16'h0000, MFR);
		rdv(fcmc_pkg::OP_ID_READ, 21'h080000, 16'h0001, DEV);
		rdv(fcmc_pkg::OP_ID_READ, 21'h088000, 16'h0002, 16'h0001);
		rdv(fcmc_pkg::OP_ID_READ, 21'h080000, 16'h0002, 16'h0000);
		rdv(fcmc_pkg::OP_READ, 21'h000123, 16'h0000, 16'h3D1F);
		run(fcmc_pkg::OP_RESET, 21'h0ABCDE, 16'h0000);
		chk(fcmc_pkg::REG_STATUS, 32'h00000000);
		rdv(fcmc_pkg::OP_READ, 21'h080456, 16'h0000, 16'h386A);
		run(fcmc_pkg::OP_ID_READ, 21'h080000, 16'h0000);
		chk(fcmc_pkg::REG_STATUS, 32'h00000002);
		wr(fcmc_pkg::REG_STATUS, 32'h00000002);
		wr(fcmc_pkg::REG_CTRL, 32'h00000002);
		run(fcmc_pkg::OP_AUTOSEL, 21'h080000, 16'h0000);
		chk(fcmc_pkg::REG_STATUS, 32'h00000002);
		wr(fcmc_pkg::REG_CTRL, 32'h00000000);
		wr(fcmc_pkg::REG_STATUS, 32'h00000002);
		$display("test autoselect done");
		run(fcmc_pkg::OP_SEC_ENTER, 21'h000000, 16'h0000);
		chk(fcmc_pkg::REG_STATUS, 32'h00000010);
		rdv(fcmc_pkg::OP_READ, 21'h000123, 16'h0000, 16'hC2E0);
		run(fcmc_pkg::OP_RESET, 21'h000000, 16'h0000);
		rdv(fcmc_pkg::OP_READ, 21'h000123, 16'h0000, 16'hC2E0);
		run(fcmc_pkg::OP_SEC_EXIT, 21'h000000, 16'h0000);
		rdv(fcmc_pkg::OP_READ, 21'h000123, 16'h0000, 16'h3D1F);
		run(fcmc_pkg::OP_SEC_ENTER, 21'h000000, 16'h0000);
		run(fcmc_pkg::OP_HW_RESET, 21'h000000, 16'h0000);
		chk(fcmc_pkg::REG_STATUS, 32'h00000000);
		rdv(fcmc_pkg::OP_READ, 21'h000123, 16'h0000, 16'h3D1F);
		$display("test secure_region done");
		run(fcmc_pkg::OP_QUERY, 21'h000000, 16'h0000);
		chk(fcmc_pkg::REG_STATUS, 32'h00000020);
		for (i = 0; i < 16; i++) begin
			rdv(fcmc_pkg::OP_QRY_READ, 21'h000000, 16'(8'h40 + i), QTAB[i]);
		end
		wr(fcmc_pkg::REG_CTRL, 32'h00000001);
		rdv(fcmc_pkg::OP_QRY_READ, 21'h000000, 16'h0040, 16'h0050);
		rdv(fcmc_pkg::OP_QRY_READ, 21'h000000, 16'h004F, BOOT);
		wr(fcmc_pkg::REG_CTRL, 32'h00000000);
		run(fcmc_pkg::OP_RESET, 21'h000000, 16'h0000);
		chk(fcmc_pkg::REG_STATUS, 32'h00000000);
		$display("test query done");
		end_sim();
	end
endmodule
`default_nettype wire
